// file: logic/strap_and_misc_pin_control.sv
// strap sampling, eeprom pins, gpio, shared clock-request/status pins and scan enable
// assumes pins synchronous to clock; pad pulls are applied by the pad ring from pad_pull
`timescale 1ns/1ns
module strap_and_misc_pin_control
#(
    parameter int unsigned GPIO_WIDTH = strap_pkg::GPIO_W,
    parameter int unsigned PORT_COUNT = strap_pkg::PORTS
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [strap_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic eeprom_serial_clock,
    input wire logic eeprom_serial_data_in,
    output logic eeprom_serial_data_out,
    output logic eeprom_serial_data_oe,
    input wire logic scan_enable_in,
    output logic scan_enable_out,
    output logic scan_enable_oe,
    input wire logic manufacturing_test,
    input wire logic [strap_pkg::GPIO_W-1:0] gpio_in,
    output logic [strap_pkg::GPIO_W-1:0] gpio_out,
    output logic [strap_pkg::GPIO_W-1:0] gpio_oe,
    input wire logic power_saving_strap,
    input wire logic status_or_substate_select,
    input wire logic smbus_select_strap,
    input wire logic debug_enable_strap,
    input wire logic [strap_pkg::PORTS-1:0] clock_request_n_in,
    output logic [strap_pkg::PORTS-1:0] clock_request_n_out,
    output logic [strap_pkg::PORTS-1:0] clock_request_n_oe,
    input wire logic [strap_pkg::PORTS-1:0] port_state,
    output logic [strap_pkg::PORTS-1:0] l1_substate_enter,
    output strap_pkg::strap_cfg_t config_out,
    output logic config_valid,
    output strap_pkg::pad_pull_t pad_pull
);
    import strap_pkg::*;

    if (GPIO_WIDTH != GPIO_W || PORT_COUNT != PORTS)
    begin : bad_param
        $error("strap_and_misc_pin_control: pin counts are fixed by the package");
    end

    // merge one byte lane of a write into an 8-bit register
    function automatic logic [7:0] lane_merge(input logic [7:0] old_val, input logic [31:0] wdata,
                                              input logic [3:0] be);
        lane_merge = be[0] ? wdata[7:0] : old_val;
    endfunction

    strap_cfg_t cfg;
    logic captured;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] gpio_oe_q;
    logic [7:0] gpio_out_q;
    logic [31:0] ee_cmd_q;
    logic ee_reject_q;
    logic ee_done_q;
    logic [PORTS-1:0] l1_q;
    logic [PORTS-1:0] status_out_q;
    logic [PORTS-1:0] share_oe_q;
    logic req;
    logic wr_take;
    logic rd_load;
    logic cmd_write;
    logic ee_start;
    logic ee_allowed;
    logic ee_busy;
    logic ee_done;
    logic [EE_DATA_W-1:0] ee_rx;
    logic [31:0] rd_mux;

    strap_capture u_strap_capture
    (
        .clock(clock),
        .rst_n(rst_n),
        .eeprom_serial_data_in(eeprom_serial_data_in),
        .power_saving_strap(power_saving_strap),
        .status_or_substate_select(status_or_substate_select),
        .smbus_select_strap(smbus_select_strap),
        .debug_enable_strap(debug_enable_strap),
        .gpio_in(gpio_in),
        .cfg(cfg),
        .captured(captured)
    );

    // avalon: one wait cycle, then the request completes on the edge with waitrequest low
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_take = avs_write & ack_q;
    assign rd_load = avs_read & ~ack_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end

    always_comb
    begin
        rd_mux = WORD_ZERO;
        if (avs_address == REG_GPIO_OE)
        begin
            rd_mux[7:0] = gpio_oe_q;
        end
        else if (avs_address == REG_GPIO_OUT)
        begin
            rd_mux[7:0] = gpio_out_q;
        end
        else if (avs_address == REG_GPIO_IN)
        begin
            rd_mux[7:0] = gpio_in;
        end
        else if (avs_address == REG_STRAP)
        begin
            rd_mux[$bits(strap_cfg_t)-1:0] = cfg;
        end
        else if (avs_address == REG_EE_CMD)
        begin
            rd_mux = ee_cmd_q;
        end
        else if (avs_address == REG_EE_STATUS)
        begin
            rd_mux[ST_BUSY_BIT] = ee_busy;
            rd_mux[ST_REJECT_BIT] = ee_reject_q;
            // the pulse covers the cycle where busy has dropped but the flag is not yet set
            rd_mux[ST_DONE_BIT] = ee_done_q | ee_done;
        end
        else if (avs_address == REG_EE_RX)
        begin
            rd_mux[EE_DATA_W-1:0] = ee_rx;
        end
        else if (avs_address == REG_PIN_STATE)
        begin
            rd_mux[PS_CLKREQ_LSB +: PORTS] = clock_request_n_in;
            rd_mux[PS_L1_LSB +: PORTS] = l1_q;
            rd_mux[PS_SCAN_IN_BIT] = scan_enable_in;
            rd_mux[PS_MFG_TEST_BIT] = manufacturing_test;
        end
        else
        begin
            rd_mux = WORD_ZERO;
        end
    end

    // read data is loaded in the wait cycle so it stands at the completing edge
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdata_q <= WORD_ZERO;
        end
        else if (rd_load)
        begin
            rdata_q <= rd_mux;
        end
    end

    assign avs_readdata = rdata_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gpio_oe_q <= GPIO_OE_RESET;
            gpio_out_q <= GPIO_OUT_RESET;
        end
        else if (wr_take)
        begin
            if (avs_address == REG_GPIO_OE)
            begin
                gpio_oe_q <= lane_merge(gpio_oe_q, avs_writedata, avs_byteenable);
            end
            else if (avs_address == REG_GPIO_OUT)
            begin
                gpio_out_q <= lane_merge(gpio_out_q, avs_writedata, avs_byteenable);
            end
        end
    end

    // oe resets low so strap-bearing gpios are not driven while they are sampled
    assign gpio_oe = gpio_oe_q;
    assign gpio_out = gpio_out_q;

    // eeprom command: accepted only after capture, with the strap high and the engine idle
    assign cmd_write = wr_take && (avs_address == REG_EE_CMD) && (avs_byteenable == 4'hF)
                       && avs_writedata[CMD_START_BIT];
    assign ee_allowed = captured & cfg.eeprom_en & ~ee_busy;
    assign ee_start = cmd_write & ee_allowed;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ee_cmd_q <= WORD_ZERO;
        end
        else if (ee_start)
        begin
            ee_cmd_q <= avs_writedata;
        end
    end

    // sticky flags: a new event in the clearing cycle wins over the write-one clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ee_reject_q <= 1'b0;
            ee_done_q <= 1'b0;
        end
        else
        begin
            if (cmd_write & ~ee_allowed)
            begin
                ee_reject_q <= 1'b1;
            end
            else if (wr_take && avs_address == REG_EE_STATUS && avs_byteenable[0]
                     && avs_writedata[ST_REJECT_BIT])
            begin
                ee_reject_q <= 1'b0;
            end
            if (ee_done)
            begin
                ee_done_q <= 1'b1;
            end
            else if (wr_take && avs_address == REG_EE_STATUS && avs_byteenable[0]
                     && avs_writedata[ST_DONE_BIT])
            begin
                ee_done_q <= 1'b0;
            end
        end
    end

    eeprom_shift
    #(
        .DATA_W(EE_DATA_W),
        .HALF_CYCLES(EE_HALF_CYCLES)
    )
    u_eeprom_shift
    (
        .clock(clock),
        .rst_n(rst_n),
        .start(ee_start),
        .read_mode(avs_writedata[CMD_READ_BIT]),
        .bit_count_m1(avs_writedata[CMD_COUNT_LSB +: CMD_COUNT_W]),
        .tx_data(avs_writedata[CMD_DATA_LSB +: EE_DATA_W]),
        .data_in(eeprom_serial_data_in),
        .serial_clock(eeprom_serial_clock),
        .data_out(eeprom_serial_data_out),
        .data_oe(eeprom_serial_data_oe),
        .busy(ee_busy),
        .done(ee_done),
        .rx_data(ee_rx)
    );

    // shared pins: clock request inputs in substate mode, port status outputs otherwise
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            l1_q <= '0;
            status_out_q <= '0;
            share_oe_q <= '0;
        end
        else
        begin
            share_oe_q <= (captured & cfg.status_mode) ? '1 : '0;
            status_out_q <= port_state;
            if (captured & ~cfg.status_mode)
            begin
                l1_q <= clock_request_n_in;
            end
            else
            begin
                l1_q <= '0;
            end
        end
    end

    assign clock_request_n_out = status_out_q;
    assign clock_request_n_oe = share_oe_q;
    assign l1_substate_enter = l1_q;

    // scan enable is released to the tester only while manufacturing test is asserted
    assign scan_enable_out = 1'b0;
    assign scan_enable_oe = ~manufacturing_test;

    assign config_out = cfg;
    assign config_valid = captured;

    // pull directions make an undriven strap read as its default
    assign pad_pull.eeprom_data_up = PULL_EEPROM_DATA;
    assign pad_pull.power_saving_up = PULL_POWER_SAVING;
    assign pad_pull.substate_select_up = PULL_SUBSTATE_SEL;
    assign pad_pull.smbus_select_up = PULL_SMBUS_SEL;

endmodule

// file: logic/strap_pkg.sv
// constants, register map and carrier types for the strap and misc pin block
// assumes a 125 MHz clock and a 32-bit avalon-mm register port
package strap_pkg;

    localparam int unsigned CLOCK_NS = 8;
    localparam int unsigned GPIO_W = 8;
    localparam int unsigned PORTS = 3;
    localparam int unsigned EE_DATA_W = 16;
    localparam int unsigned ADDR_W = 5;

    // eeprom serial clock half period, in ns, and its cycle count (longest time rounds down)
    localparam int unsigned EE_HALF_NS = 5000;
    localparam int unsigned EE_HALF_CYCLES = (EE_HALF_NS / CLOCK_NS) < 1 ? 1 : (EE_HALF_NS / CLOCK_NS);

    // byte addresses
    localparam logic [4:0] REG_GPIO_OE = 5'h00;
    localparam logic [4:0] REG_GPIO_OUT = 5'h04;
    localparam logic [4:0] REG_GPIO_IN = 5'h08;
    localparam logic [4:0] REG_STRAP = 5'h0C;
    localparam logic [4:0] REG_EE_CMD = 5'h10;
    localparam logic [4:0] REG_EE_STATUS = 5'h14;
    localparam logic [4:0] REG_EE_RX = 5'h18;
    localparam logic [4:0] REG_PIN_STATE = 5'h1C;

    // eeprom command fields
    localparam int unsigned CMD_DATA_LSB = 0;
    localparam int unsigned CMD_COUNT_LSB = 16;
    localparam int unsigned CMD_COUNT_W = 4;
    localparam int unsigned CMD_READ_BIT = 24;
    localparam int unsigned CMD_START_BIT = 31;

    // eeprom status fields
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_REJECT_BIT = 1;
    localparam int unsigned ST_DONE_BIT = 2;

    // pin state fields
    localparam int unsigned PS_CLKREQ_LSB = 0;
    localparam int unsigned PS_L1_LSB = 4;
    localparam int unsigned PS_SCAN_IN_BIT = 8;
    localparam int unsigned PS_MFG_TEST_BIT = 9;

    localparam logic [7:0] GPIO_OE_RESET = 8'h00;
    localparam logic [7:0] GPIO_OUT_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // internal pad pulls: 1 pulls up, 0 pulls down
    localparam logic PULL_EEPROM_DATA = 1'b1;
    localparam logic PULL_POWER_SAVING = 1'b1;
    localparam logic PULL_SUBSTATE_SEL = 1'b0;
    localparam logic PULL_SMBUS_SEL = 1'b0;

    localparam int unsigned MGMT_ADDR_LSB = 5;
    localparam int unsigned DEBUG_SEL_W = 5;

    typedef struct packed {
        logic eeprom_en;
        logic power_save_en;
        logic status_mode;
        logic smbus_sel;
        logic debug_mode;
        logic [2:0] mgmt_addr;
        logic [4:0] debug_sel;
    } strap_cfg_t;

    localparam strap_cfg_t STRAP_RESET = '{eeprom_en: PULL_EEPROM_DATA, power_save_en: PULL_POWER_SAVING,
        status_mode: PULL_SUBSTATE_SEL, smbus_sel: PULL_SMBUS_SEL, debug_mode: 1'b0,
        mgmt_addr: 3'h0, debug_sel: 5'h00};

    typedef struct packed {
        logic eeprom_data_up;
        logic power_saving_up;
        logic substate_select_up;
        logic smbus_select_up;
    } pad_pull_t;

endpackage

// file: logic/strap_capture.sv
// captures every strap level once, in the first cycle after reset release
// assumes strap pins are steady and synchronous to clock around the release
`timescale 1ns/1ns
module strap_capture
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic eeprom_serial_data_in,
    input wire logic power_saving_strap,
    input wire logic status_or_substate_select,
    input wire logic smbus_select_strap,
    input wire logic debug_enable_strap,
    input wire logic [strap_pkg::GPIO_W-1:0] gpio_in,
    output strap_pkg::strap_cfg_t cfg,
    output logic captured
);
    import strap_pkg::*;

    strap_cfg_t cfg_q;
    logic captured_q;

    // reset loads constants; the pin levels are caught by the clocked release cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cfg_q <= STRAP_RESET;
            captured_q <= 1'b0;
        end
        else if (!captured_q)
        begin
            cfg_q.eeprom_en <= eeprom_serial_data_in;
            cfg_q.power_save_en <= power_saving_strap;
            cfg_q.status_mode <= status_or_substate_select;
            cfg_q.smbus_sel <= smbus_select_strap;
            cfg_q.debug_mode <= ~debug_enable_strap;
            cfg_q.mgmt_addr <= gpio_in[MGMT_ADDR_LSB +: 3];
            cfg_q.debug_sel <= gpio_in[DEBUG_SEL_W-1:0];
            captured_q <= 1'b1;
        end
    end

    assign cfg = cfg_q;
    assign captured = captured_q;

endmodule

// file: logic/eeprom_shift.sv
// bit-serial engine for the eeprom pins: msb first, data changes while clock is low
// assumes the caller only pulses start while busy is low
`timescale 1ns/1ns
module eeprom_shift
#(
    parameter int unsigned DATA_W = strap_pkg::EE_DATA_W,
    parameter int unsigned HALF_CYCLES = strap_pkg::EE_HALF_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic read_mode,
    input wire logic [3:0] bit_count_m1,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic data_in,
    output logic serial_clock,
    output logic data_out,
    output logic data_oe,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rx_data
);
    import strap_pkg::*;

    if (DATA_W != 16 || HALF_CYCLES < 1 || HALF_CYCLES > 4096)
    begin : bad_param
        $error("eeprom_shift: unsupported parameters");
    end

    typedef enum logic [1:0] {IDLE, LOW_PHASE, HIGH_PHASE} shift_state_t;

    shift_state_t state_q;
    logic [12:0] tick_q;
    logic [3:0] left_q;
    logic [DATA_W-1:0] shift_q;
    logic [DATA_W-1:0] rx_q;
    logic read_q;
    logic clk_q;
    logic oe_q;
    logic done_q;
    logic half_end;

    assign half_end = (tick_q == 13'(HALF_CYCLES - 1));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= IDLE;
            tick_q <= '0;
            left_q <= '0;
            shift_q <= '0;
            rx_q <= '0;
            read_q <= 1'b0;
            clk_q <= 1'b0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            tick_q <= half_end ? 13'h0000 : tick_q + 13'h0001;
            case (state_q)
                IDLE:
                begin
                    tick_q <= '0;
                    if (start)
                    begin
                        state_q <= LOW_PHASE;
                        left_q <= bit_count_m1;
                        shift_q <= tx_data << (4'hF - bit_count_m1);
                        read_q <= read_mode;
                        oe_q <= ~read_mode;
                    end
                end
                LOW_PHASE:
                begin
                    if (half_end)
                    begin
                        state_q <= HIGH_PHASE;
                        clk_q <= 1'b1;
                        if (read_q)
                        begin
                            rx_q <= {rx_q[DATA_W-2:0], data_in};
                        end
                    end
                end
                HIGH_PHASE:
                begin
                    if (half_end)
                    begin
                        clk_q <= 1'b0;
                        shift_q <= {shift_q[DATA_W-2:0], 1'b0};
                        if (left_q == 4'h0)
                        begin
                            state_q <= IDLE;
                            oe_q <= 1'b0;
                            done_q <= 1'b1;
                        end
                        else
                        begin
                            left_q <= left_q - 4'h1;
                            state_q <= LOW_PHASE;
                        end
                    end
                end
                default:
                begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    assign serial_clock = clk_q;
    assign data_out = shift_q[DATA_W-1];
    assign data_oe = oe_q;
    assign busy = (state_q != IDLE);
    assign done = done_q;
    assign rx_data = rx_q;

endmodule

// file: tb/strap_pins_properties.sv
// checker for the strap and misc pin block, bound to its top module
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ns
module strap_pins_properties
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scan_enable_out,
    input wire logic scan_enable_oe,
    input wire logic manufacturing_test,
    input wire logic eeprom_serial_clock,
    input wire logic eeprom_serial_data_oe,
    input wire logic [strap_pkg::PORTS-1:0] clock_request_n_in,
    input wire logic [strap_pkg::PORTS-1:0] clock_request_n_out,
    input wire logic [strap_pkg::PORTS-1:0] clock_request_n_oe,
    input wire logic [strap_pkg::PORTS-1:0] port_state,
    input wire logic [strap_pkg::PORTS-1:0] l1_substate_enter,
    input wire strap_pkg::strap_cfg_t config_out,
    input wire logic config_valid,
    input wire strap_pkg::pad_pull_t pad_pull
);
    import strap_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_scan_out;
        !manufacturing_test |-> scan_enable_oe && !scan_enable_out;
    endproperty
    a_scan_out: assert property (p_scan_out) else $error("scan pin not driving 0");
    property p_scan_in;
        manufacturing_test |-> !scan_enable_oe;
    endproperty
    a_scan_in: assert property (p_scan_in) else $error("scan pin driven in test");
    property p_cfg_hold;
        config_valid && $past(config_valid) |-> $stable(config_out);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("captured straps moved");
    property p_ee_idle;
        !config_valid |-> !eeprom_serial_clock && !eeprom_serial_data_oe;
    endproperty
    a_ee_idle: assert property (p_ee_idle) else $error("eeprom pins busy before capture");
    property p_ee_off;
        config_valid && !config_out.eeprom_en |-> !eeprom_serial_clock && !eeprom_serial_data_oe;
    endproperty
    a_ee_off: assert property (p_ee_off) else $error("eeprom active while disabled");
    // the half period is hundreds of cycles, so eight is a safe floor
    property p_clk_high;
        $rose(eeprom_serial_clock) |-> eeprom_serial_clock [*8];
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("eeprom clock high phase short");
    property p_status;
        $past(config_valid) && config_out.status_mode |->
            clock_request_n_oe == 3'h7 && clock_request_n_out == $past(port_state) && l1_substate_enter == 3'h0;
    endproperty
    a_status: assert property (p_status) else $error("status pins wrong");
    property p_substate;
        $past(config_valid) && !config_out.status_mode |->
            clock_request_n_oe == 3'h0 && l1_substate_enter == $past(clock_request_n_in);
    endproperty
    a_substate: assert property (p_substate) else $error("substate control wrong");
    property p_pull;
        config_valid |-> pad_pull == 4'hC;
    endproperty
    a_pull: assert property (p_pull) else $error("pad pulls wrong");
endmodule
bind strap_and_misc_pin_control strap_pins_properties strap_pins_properties_inst (.clock, .rst_n,
    .scan_enable_out, .scan_enable_oe, .manufacturing_test, .eeprom_serial_clock, .eeprom_serial_data_oe,
    .clock_request_n_in, .clock_request_n_out, .clock_request_n_oe, .port_state, .l1_substate_enter,
    .config_out, .config_valid, .pad_pull);

// file: tb/eeprom_board_model.sv
// board straps and serial eeprom on the far side of the eeprom pins
// assumes the serial clock is made in the same clock domain
`timescale 1ns/1ns
module eeprom_board_model
#(
    parameter logic [15:0] PATTERN = 16'hB000
)
(
    input wire logic clock,
    input wire logic eeprom_serial_clock,
    input wire logic eeprom_serial_data_out,
    input wire logic eeprom_serial_data_oe,
    input wire logic strap_low,
    input wire logic talk,
    output logic eeprom_serial_data_in,
    output logic [15:0] captured_q
);
    logic sclk_q = 1'b0;
    logic [15:0] pattern_q = 16'h0000;
    // a board pull-down beats the pad pull-up; a released line floats up
    assign eeprom_serial_data_in = eeprom_serial_data_oe ? eeprom_serial_data_out :
        strap_low ? 1'b0 : talk ? pattern_q[15] : 1'b1;
    always_ff @(posedge clock)
    begin
        sclk_q <= eeprom_serial_clock;
        if (!talk)
            pattern_q <= PATTERN;
        else if (sclk_q && !eeprom_serial_clock)
            pattern_q <= {pattern_q[14:0], 1'b0};
        if (eeprom_serial_data_oe && !sclk_q && eeprom_serial_clock)
            captured_q <= {captured_q[14:0], eeprom_serial_data_out};
    end
endmodule

// file: tb/tb.sv
// self-checking bench for the strap and misc pin block
// assumes the board model on the eeprom pins and the bound checker
`timescale 1ns/1ns
module tb;
    import strap_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, eeprom_serial_clock, eeprom_serial_data_in, eeprom_serial_data_out;
    logic eeprom_serial_data_oe, scan_enable_out, scan_enable_oe, config_valid;
    logic scan_enable_in = 1'b0;
    logic manufacturing_test = 1'b0;
    logic [7:0] gpio_in = 8'h00;
    logic [7:0] gpio_out, gpio_oe;
    logic power_saving_strap = 1'b1;
    logic status_or_substate_select = 1'b0;
    logic smbus_select_strap = 1'b0;
    logic debug_enable_strap = 1'b1;
    logic [2:0] clock_request_n_in = 3'h7;
    logic [2:0] port_state = 3'h0;
    logic [2:0] clock_request_n_out, clock_request_n_oe, l1_substate_enter;
    strap_cfg_t config_out;
    pad_pull_t pad_pull;
    logic strap_low = 1'b0;
    logic talk = 1'b0;
    logic [15:0] captured;
    logic [31:0] q;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    always #4 clock = ~clock;
    strap_and_misc_pin_control strap_and_misc_pin_control_inst (.clock, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .eeprom_serial_clock,
        .eeprom_serial_data_in, .eeprom_serial_data_out, .eeprom_serial_data_oe, .scan_enable_in,
        .scan_enable_out, .scan_enable_oe, .manufacturing_test, .gpio_in, .gpio_out, .gpio_oe,
        .power_saving_strap, .status_or_substate_select, .smbus_select_strap, .debug_enable_strap,
        .clock_request_n_in, .clock_request_n_out, .clock_request_n_oe, .port_state, .l1_substate_enter,
        .config_out, .config_valid, .pad_pull);
    eeprom_board_model eeprom_board_model_inst (.clock, .eeprom_serial_clock, .eeprom_serial_data_out,
        .eeprom_serial_data_oe, .strap_low, .talk, .eeprom_serial_data_in, .captured_q(captured));
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0)
            @(posedge clock);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic restart(input logic ee_low, input logic [3:0] s, input logic [7:0] g);
        @(posedge clock);
        rst_n <= 1'b0;
        strap_low <= ee_low;
        {power_saving_strap, status_or_substate_select, smbus_select_strap, debug_enable_strap} <= s;
        gpio_in <= g;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
    endtask
    // polls busy; an unknown busy ends the loop and shows up in the checks
    task automatic ee_wait(output logic saw);
        saw = 1'b0;
        q = 32'h0000_0001;
        while (q[ST_BUSY_BIT] === 1'b1)
        begin
            saw |= eeprom_serial_data_oe;
            bus(1'b0, REG_EE_STATUS, 32'h0000_0000);
        end
    endtask
    task automatic t_default();
        restart(1'b0, 4'h9, 8'hA5);
        bus(1'b0, REG_STRAP, 32'h0000_0000);
        check(q, 32'h0000_18A5);
        check({config_valid, pad_pull}, 32'h0000_001C);
        bus(1'b0, REG_GPIO_OE, 32'h0000_0000);
        check(q, 32'h0000_0000);
        bus(1'b1, REG_GPIO_OE, 32'h0000_000F);
        bus(1'b1, REG_GPIO_OUT, 32'h0000_0055);
        @(negedge clock);
        check({gpio_oe, gpio_out}, 32'h0000_0F55);
        bus(1'b0, REG_GPIO_IN, 32'h0000_0000);
        check(q, 32'h0000_00A5);
        bus(1'b0, 5'h02, 32'h0000_0000);
        check(q, 32'h0000_0000);
        gpio_in <= 8'h3C;
        power_saving_strap <= 1'b0;
        clock_request_n_in <= 3'h5;
        manufacturing_test <= 1'b1;
        bus(1'b0, REG_STRAP, 32'h0000_0000);
        check(q, 32'h0000_18A5);
        bus(1'b0, REG_PIN_STATE, 32'h0000_0000);
        check(q, 32'h0000_0255);
        check({scan_enable_oe, scan_enable_out}, 32'h0000_0000);
        manufacturing_test <= 1'b0;
    endtask
    task automatic t_strap_alt();
        restart(1'b1, 4'h6, 8'h3A);
        bus(1'b0, REG_STRAP, 32'h0000_0000);
        check(q, 32'h0000_073A);
        port_state <= 3'h6;
        bus(1'b1, REG_EE_CMD, 32'h8001_0002);
        bus(1'b0, REG_EE_STATUS, 32'h0000_0000);
        check(q, 32'h0000_0002);
        check({clock_request_n_oe, clock_request_n_out}, 32'h0000_003E);
    endtask
    task automatic t_ee_write();
        logic saw;
        restart(1'b0, 4'h9, 8'h00);
        bus(1'b1, REG_EE_CMD, 32'h8001_0002);
        // a second start while busy must be refused
        bus(1'b1, REG_EE_CMD, 32'h8001_0001);
        ee_wait(saw);
        check({saw, captured[1:0]}, 32'h0000_0006);
        check(q, 32'h0000_0006);
    endtask
    task automatic t_ee_read();
        logic saw;
        restart(1'b0, 4'h9, 8'h00);
        talk <= 1'b1;
        bus(1'b1, REG_EE_CMD, 32'h8103_0000);
        ee_wait(saw);
        talk <= 1'b0;
        bus(1'b0, REG_EE_RX, 32'h0000_0000);
        check({saw, q[3:0]}, 32'h0000_000B);
    endtask
    initial
    begin
        t_default();
        t_strap_alt();
        t_ee_write();
        t_ee_read();
        finish_test();
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
endmodule
